// >>> logic/pbd_cfg_regs.sv
/*
 * host bridge configuration address and data registers.
 * assumes the decoder hands it single-cycle write strobes already decoded.
 */
`timescale 1ns/10ps
module pbd_cfg_regs (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        wr_addr_stb,
    input  wire logic        wr_data_stb,
    input  wire logic [31:0] wdata,
    output logic      [31:0] cfg_address,
    output logic      [31:0] cfg_data
);
    import pbd_pkg::*;

    logic [31:0] cfg_address_ff;
    logic [31:0] cfg_data_ff;
    logic [31:0] nxt_cfg_address;
    logic [31:0] nxt_cfg_data;

    // each register loads only on its own strobe
    always_comb begin
        nxt_cfg_address = wr_addr_stb ? wdata : cfg_address_ff;
        nxt_cfg_data    = wr_data_stb ? wdata : cfg_data_ff;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_address_ff <= PBD_CFG_ADDR_RST;
            cfg_data_ff    <= PBD_CFG_DATA_RST;
        end else begin
            cfg_address_ff <= nxt_cfg_address;
            cfg_data_ff    <= nxt_cfg_data;
        end
    end

    assign cfg_address = cfg_address_ff;
    assign cfg_data    = cfg_data_ff;
endmodule : pbd_cfg_regs

// >>> logic/pbd_decoder.sv
/*
 * processor bus default decoder: steers each processor address to one target
 * of the power-up map, or flags it unmapped, one clock after it is presented.
 * assumes a processor bus master presents addr with addr_valid for one cycle,
 * and that the remapping logic raises map_load when new settings are in place.
 */
`timescale 1ns/10ps
module pbd_decoder #(
    parameter int FLASH_OFS_W = 22
) (
    input  wire logic                            core_clk,
    input  wire logic                            rstn,
    input  wire logic [31:0]                     addr,
    input  wire logic                            addr_valid,
    input  wire logic                            write_en,
    input  wire logic [31:0]                     wdata,
    input  wire logic                            boot_flash_bank_select,
    input  wire logic                            boot_bank_jumper,
    input  wire logic                            map_load,
    output logic                                 sel_pci_io,
    output logic                                 sel_mem_ctrl,
    output logic                                 sel_host_regs,
    output logic                                 sel_flash_a,
    output logic                                 sel_flash_b,
    output logic                                 unmapped,
    output logic [pbd_pkg::PBD_IO_OFS_W-1:0]     io_offset,
    output logic [FLASH_OFS_W-1:0]               flash_offset,
    output logic [31:0]                          rdata,
    output logic                                 rdata_valid,
    output logic                                 cfg_cycle,
    output logic                                 default_map
);
    import pbd_pkg::*;

    // inclusive window compare on the full address
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    pbd_map_state_type              map_state_ff;
    pbd_map_state_type              nxt_map_state;
    logic                           sel_pci_io_ff;
    logic                           sel_mem_ctrl_ff;
    logic                           sel_host_regs_ff;
    logic                           sel_flash_a_ff;
    logic                           sel_flash_b_ff;
    logic                           unmapped_ff;
    logic [PBD_IO_OFS_W-1:0]        io_offset_ff;
    logic [FLASH_OFS_W-1:0]         flash_offset_ff;
    logic [31:0]                    rdata_ff;
    logic                           rdata_valid_ff;
    logic                           cfg_cycle_ff;
    logic                           nxt_sel_pci_io;
    logic                           nxt_sel_mem_ctrl;
    logic                           nxt_sel_host_regs;
    logic                           nxt_sel_flash_a;
    logic                           nxt_sel_flash_b;
    logic                           nxt_unmapped;
    logic [PBD_IO_OFS_W-1:0]        nxt_io_offset;
    logic [FLASH_OFS_W-1:0]         nxt_flash_offset;
    logic [31:0]                    nxt_rdata;
    logic                           nxt_rdata_valid;
    logic                           nxt_cfg_cycle;
    logic                           hit_io;
    logic                           hit_mem;
    logic                           hit_host;
    logic                           hit_boot;
    logic                           hole;
    logic                           use_bank_b;
    logic                           on_default;
    logic [PBD_IO_OFS_W-1:0]        ofs;
    logic                           at_cfg_addr;
    logic                           at_cfg_data;
    logic                           wr_addr_stb;
    logic                           wr_data_stb;
    logic [31:0]                    cfg_address;
    logic [31:0]                    cfg_data;

    // map state: default from reset, left only when new settings load
    always_comb begin
        nxt_map_state = map_state_ff;
        unique case (map_state_ff)
            PBD_MAP_DEFAULT: begin
                if (map_load) begin
                    nxt_map_state = PBD_MAP_LOADED;
                end
            end
            PBD_MAP_LOADED: begin
                nxt_map_state = PBD_MAP_LOADED;
            end
            default: begin
                nxt_map_state = PBD_MAP_DEFAULT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            map_state_ff <= PBD_MAP_DEFAULT;
        end else begin
            map_state_ff <= nxt_map_state;
        end
    end

    assign on_default = (map_state_ff == PBD_MAP_DEFAULT);

    // region hits; holes are listed explicitly so a gap in the table shows
    assign hit_io   = in_range(addr, PBD_PCI_IO_LO, PBD_PCI_IO_HI);
    assign hit_mem  = in_range(addr, PBD_MEM_CTRL_LO, PBD_MEM_CTRL_HI);
    assign hit_host = in_range(addr, PBD_HOST_REGS_LO, PBD_HOST_REGS_HI);
    assign hit_boot = in_range(addr, PBD_BOOT_FLASH_LO, PBD_BOOT_FLASH_HI);
    assign hole     = in_range(addr, PBD_LOW_HOLE_LO, PBD_LOW_HOLE_HI)
                    | in_range(addr, PBD_MID_HOLE_LO, PBD_MID_HOLE_HI)
                    | in_range(addr, PBD_REG_HOLE_LO, PBD_REG_HOLE_HI)
                    | in_range(addr, PBD_TOP_HOLE_LO, PBD_TOP_HOLE_HI);

    // jumper forces bank B so the reset vector fetch lands in the socket
    assign use_bank_b = boot_flash_bank_select | boot_bank_jumper;

    // config register hits inside the io window, word aligned only
    assign ofs         = addr[PBD_IO_OFS_W-1:0];
    assign at_cfg_addr = hit_io && (ofs == PBD_CFG_ADDR_OFS);
    assign at_cfg_data = hit_io && (ofs == PBD_CFG_DATA_OFS);
    assign wr_addr_stb = addr_valid && on_default && write_en && at_cfg_addr;
    assign wr_data_stb = addr_valid && on_default && write_en && at_cfg_data;

    pbd_cfg_regs u_cfg_regs (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .wr_addr_stb (wr_addr_stb),
        .wr_data_stb (wr_data_stb),
        .wdata       (wdata),
        .cfg_address (cfg_address),
        .cfg_data    (cfg_data)
    );

    // decode; after a map load this block goes quiet and the loaded decoders own the bus
    always_comb begin
        nxt_sel_pci_io    = 1'b0;
        nxt_sel_mem_ctrl  = 1'b0;
        nxt_sel_host_regs = 1'b0;
        nxt_sel_flash_a   = 1'b0;
        nxt_sel_flash_b   = 1'b0;
        nxt_unmapped      = 1'b0;
        nxt_io_offset     = io_offset_ff;
        nxt_flash_offset  = flash_offset_ff;
        nxt_rdata         = rdata_ff;
        nxt_rdata_valid   = 1'b0;
        nxt_cfg_cycle     = 1'b0;
        if (addr_valid && on_default) begin
            // the regions are disjoint, so at most one select can rise
            nxt_sel_pci_io    = hit_io;
            nxt_sel_mem_ctrl  = hit_mem;
            nxt_sel_host_regs = hit_host;
            nxt_sel_flash_a   = hit_boot && !use_bank_b;
            nxt_sel_flash_b   = hit_boot && use_bank_b;
            nxt_unmapped      = hole;
            if (hit_io) begin
                nxt_io_offset = ofs;
            end
            if (hit_boot) begin
                // upper bank bits stay zero: only the first 1MB is visible
                nxt_flash_offset = {{(FLASH_OFS_W-PBD_BOOT_OFS_W){1'b0}},
                                    addr[PBD_BOOT_OFS_W-1:0]};
            end
            if (at_cfg_addr || at_cfg_data) begin
                nxt_cfg_cycle = 1'b1;
                if (!write_en) begin
                    nxt_rdata       = at_cfg_addr ? cfg_address : cfg_data;
                    nxt_rdata_valid = 1'b1;
                end
            end
        end
    end

    // every output straight from a flop, one clock after the address
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_pci_io_ff    <= 1'b0;
            sel_mem_ctrl_ff  <= 1'b0;
            sel_host_regs_ff <= 1'b0;
            sel_flash_a_ff   <= 1'b0;
            sel_flash_b_ff   <= 1'b0;
            unmapped_ff      <= 1'b0;
            io_offset_ff     <= '0;
            flash_offset_ff  <= '0;
            rdata_ff         <= 32'h0000_0000;
            rdata_valid_ff   <= 1'b0;
            cfg_cycle_ff     <= 1'b0;
        end else begin
            sel_pci_io_ff    <= nxt_sel_pci_io;
            sel_mem_ctrl_ff  <= nxt_sel_mem_ctrl;
            sel_host_regs_ff <= nxt_sel_host_regs;
            sel_flash_a_ff   <= nxt_sel_flash_a;
            sel_flash_b_ff   <= nxt_sel_flash_b;
            unmapped_ff      <= nxt_unmapped;
            io_offset_ff     <= nxt_io_offset;
            flash_offset_ff  <= nxt_flash_offset;
            rdata_ff         <= nxt_rdata;
            rdata_valid_ff   <= nxt_rdata_valid;
            cfg_cycle_ff     <= nxt_cfg_cycle;
        end
    end

    assign sel_pci_io    = sel_pci_io_ff;
    assign sel_mem_ctrl  = sel_mem_ctrl_ff;
    assign sel_host_regs = sel_host_regs_ff;
    assign sel_flash_a   = sel_flash_a_ff;
    assign sel_flash_b   = sel_flash_b_ff;
    assign unmapped      = unmapped_ff;
    assign io_offset     = io_offset_ff;
    assign flash_offset  = flash_offset_ff;
    assign rdata         = rdata_ff;
    assign rdata_valid   = rdata_valid_ff;
    assign cfg_cycle     = cfg_cycle_ff;
    assign default_map   = map_state_ff[0]; // state flop bit, high in default state
endmodule : pbd_decoder

// >>> pkg/pbd_pkg.sv
/*
 * constants for the processor bus default decoder: region bounds of the
 * power-up map, host bridge configuration register offsets, reset values.
 * assumes a 32-bit processor address and byte offsets inside the io window.
 */
package pbd_pkg;
    // default map region bounds, inclusive
    localparam logic [31:0] PBD_LOW_HOLE_LO   = 32'h0000_0000;
    localparam logic [31:0] PBD_LOW_HOLE_HI   = 32'h7FFF_FFFF;
    localparam logic [31:0] PBD_PCI_IO_LO     = 32'h8000_0000;
    localparam logic [31:0] PBD_PCI_IO_HI     = 32'h8001_FFFF;
    localparam logic [31:0] PBD_MID_HOLE_LO   = 32'h8002_0000;
    localparam logic [31:0] PBD_MID_HOLE_HI   = 32'hFEF7_FFFF;
    localparam logic [31:0] PBD_MEM_CTRL_LO   = 32'hFEF8_0000;
    localparam logic [31:0] PBD_MEM_CTRL_HI   = 32'hFEF8_FFFF;
    localparam logic [31:0] PBD_REG_HOLE_LO   = 32'hFEF9_0000;
    localparam logic [31:0] PBD_REG_HOLE_HI   = 32'hFEFE_FFFF;
    localparam logic [31:0] PBD_HOST_REGS_LO  = 32'hFEFF_0000;
    localparam logic [31:0] PBD_HOST_REGS_HI  = 32'hFEFF_FFFF;
    localparam logic [31:0] PBD_TOP_HOLE_LO   = 32'hFF00_0000;
    localparam logic [31:0] PBD_TOP_HOLE_HI   = 32'hFFEF_FFFF;
    localparam logic [31:0] PBD_BOOT_FLASH_LO = 32'hFFF0_0000;
    localparam logic [31:0] PBD_BOOT_FLASH_HI = 32'hFFFF_FFFF;

    // offsets from the pci io base
    localparam logic [16:0] PBD_CFG_ADDR_OFS  = 17'h0_0CF8;
    localparam logic [16:0] PBD_CFG_DATA_OFS  = 17'h0_0CFC;
    localparam int          PBD_IO_OFS_W      = 17;
    // boot window is 1MB: 20 offset bits
    localparam int          PBD_BOOT_OFS_W    = 20;

    localparam logic [31:0] PBD_CFG_ADDR_RST  = 32'h0000_0000;
    localparam logic [31:0] PBD_CFG_DATA_RST  = 32'h0000_0000;

    typedef enum logic [1:0] {
        PBD_MAP_DEFAULT = 2'b01,
        PBD_MAP_LOADED  = 2'b10
    } pbd_map_state_type;
endpackage : pbd_pkg

// >>> tb/pbd_bus_master.sv
/* processor bus master model: one addressed transfer per call.
   assumes the caller waits for each call to return before the next. */
`timescale 1ns/10ps
module pbd_bus_master (
    input  wire logic        core_clk,
    output logic      [31:0] addr,
    output logic             addr_valid,
    output logic             write_en,
    output logic      [31:0] wdata
);
    // idle bus at time zero
    initial begin
        addr = 32'h0000_0000;
        addr_valid = 1'b0;
        write_en = 1'b0;
        wdata = 32'h0000_0000;
    end

    // hold keeps valid up so the next call runs back to back
    task automatic req(input logic [31:0] a, input logic we, input logic [31:0] d, input bit hold);
        @(negedge core_clk);
        addr = a;
        addr_valid = 1'b1;
        write_en = we;
        wdata = d;
        @(posedge core_clk);
        if (!hold) begin
            @(negedge core_clk);
            addr_valid = 1'b0;
            addr = ~addr; // released address and data lines never keep the old value
            wdata = ~wdata;
        end
    endtask : req
endmodule : pbd_bus_master

// >>> tb/pbd_monitor.sv
/* checker for the default decoder: routing, select timing, config hits.
   assumes it is bound to pbd_decoder and sees only its ports. */
`timescale 1ns/10ps
module pbd_monitor #(
    parameter int FLASH_OFS_W = 22
) (
    input wire logic                   core_clk,
    input wire logic                   rstn,
    input wire logic [31:0]            addr,
    input wire logic                   addr_valid,
    input wire logic                   boot_flash_bank_select,
    input wire logic                   boot_bank_jumper,
    input wire logic                   map_load,
    input wire logic                   sel_pci_io,
    input wire logic                   sel_mem_ctrl,
    input wire logic                   sel_host_regs,
    input wire logic                   sel_flash_a,
    input wire logic                   sel_flash_b,
    input wire logic                   unmapped,
    input wire logic [FLASH_OFS_W-1:0] flash_offset,
    input wire logic                   cfg_cycle,
    input wire logic                   default_map
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic       tk;
    logic [5:0] hit;
    // a decode only counts while the default map rules
    assign tk = addr_valid && default_map;
    assign hit = {sel_pci_io, sel_mem_ctrl, sel_host_regs, sel_flash_a, sel_flash_b, unmapped};

    function automatic bit inr(logic [31:0] a, logic [31:0] lo, logic [31:0] hi);
        return a >= lo && a <= hi;
    endfunction : inr

    a_sel_onehot: assert property ($onehot0(hit))
        else $error("two selects at once");
    a_hole_unmapped: assert property (tk && (inr(addr, 32'h0000_0000, 32'h7FFF_FFFF)
        || inr(addr, 32'h8002_0000, 32'hFEF7_FFFF) || inr(addr, 32'hFEF9_0000, 32'hFEFE_FFFF)
        || inr(addr, 32'hFF00_0000, 32'hFFEF_FFFF)) |=> hit == 6'h01) else $error("hole not flagged");
    a_pci_window: assert property (tk && inr(addr, 32'h8000_0000, 32'h8001_FFFF) |=> hit == 6'h20)
        else $error("io window miss");
    a_mem_ctrl: assert property (tk && inr(addr, 32'hFEF8_0000, 32'hFEF8_FFFF) |=> hit == 6'h10)
        else $error("memory controller miss");
    a_host_regs: assert property (tk && inr(addr, 32'hFEFF_0000, 32'hFEFF_FFFF) |=> hit == 6'h08)
        else $error("host registers miss");
    a_boot_bank: assert property (tk && addr >= 32'hFFF0_0000 |=>
        hit == ($past(boot_flash_bank_select | boot_bank_jumper) ? 6'h02 : 6'h04)) else $error("wrong bank");
    a_boot_offset: assert property (tk && addr >= 32'hFFF0_0000 |=>
        flash_offset == FLASH_OFS_W'($past(addr[19:0]))) else $error("boot offset wrong");
    a_cfg_hit: assert property (tk && (addr == 32'h8000_0CF8 || addr == 32'h8000_0CFC) |=>
        cfg_cycle && sel_pci_io) else $error("config hit missed");
    a_map_hold: assert property ($fell(default_map) |-> $past(map_load))
        else $error("default map left early");
    a_idle_quiet: assert property (!tk |=> hit == 6'h00)
        else $error("select without request");

    cover property (tk ##1 sel_flash_b);
    cover property (tk ##1 cfg_cycle);
    cover property (map_load ##1 !default_map);
endmodule : pbd_monitor

bind pbd_decoder pbd_monitor #(.FLASH_OFS_W(FLASH_OFS_W)) u_mon (
    .core_clk               (core_clk),
    .rstn                   (rstn),
    .addr                   (addr),
    .addr_valid             (addr_valid),
    .boot_flash_bank_select (boot_flash_bank_select),
    .boot_bank_jumper       (boot_bank_jumper),
    .map_load               (map_load),
    .sel_pci_io             (sel_pci_io),
    .sel_mem_ctrl           (sel_mem_ctrl),
    .sel_host_regs          (sel_host_regs),
    .sel_flash_a            (sel_flash_a),
    .sel_flash_b            (sel_flash_b),
    .unmapped               (unmapped),
    .flash_offset           (flash_offset),
    .cfg_cycle              (cfg_cycle),
    .default_map            (default_map)
);

// >>> tb/tb.sv
/* self-checking bench for the default decoder.
   assumes pbd_bus_master drives the processor side at falling edges. */
`timescale 1ns/10ps
module tb;
    typedef struct {logic [31:0] a; logic [5:0] e;} pbd_row_type;
    logic        core_clk, rstn, boot_flash_bank_select, boot_bank_jumper, map_load;
    logic [31:0] addr, wdata, rdata;
    logic        addr_valid, write_en, rdata_valid, cfg_cycle, default_map;
    logic        sel_pci_io, sel_mem_ctrl, sel_host_regs, sel_flash_a, sel_flash_b, unmapped;
    logic [16:0] io_offset;
    logic [21:0] flash_offset;
    logic [5:0]  hit;
    int          errors, comparisons;
    // region bounds with the select pattern each should give
    pbd_row_type rows[16] = '{
        '{32'h0000_0000, 6'h01}, '{32'h7FFF_FFFF, 6'h01}, '{32'h8000_0000, 6'h20}, '{32'h8001_FFFF, 6'h20},
        '{32'h8002_0000, 6'h01}, '{32'hFEF7_FFFF, 6'h01}, '{32'hFEF8_0000, 6'h10}, '{32'hFEF8_FFFF, 6'h10},
        '{32'hFEF9_0000, 6'h01}, '{32'hFEFE_FFFF, 6'h01}, '{32'hFEFF_0000, 6'h08}, '{32'hFEFF_FFFF, 6'h08},
        '{32'hFF00_0000, 6'h01}, '{32'hFFEF_FFFF, 6'h01}, '{32'hFFF0_0000, 6'h04}, '{32'hFFFF_FFFF, 6'h04}};
    assign hit = {sel_pci_io, sel_mem_ctrl, sel_host_regs, sel_flash_a, sel_flash_b, unmapped};

    pbd_bus_master u_m (.core_clk(core_clk), .addr(addr), .addr_valid(addr_valid),
        .write_en(write_en), .wdata(wdata));
    pbd_decoder u_dut (.core_clk(core_clk), .rstn(rstn), .addr(addr), .addr_valid(addr_valid),
        .write_en(write_en), .wdata(wdata), .boot_flash_bank_select(boot_flash_bank_select),
        .boot_bank_jumper(boot_bank_jumper), .map_load(map_load), .sel_pci_io(sel_pci_io),
        .sel_mem_ctrl(sel_mem_ctrl), .sel_host_regs(sel_host_regs), .sel_flash_a(sel_flash_a),
        .sel_flash_b(sel_flash_b), .unmapped(unmapped), .io_offset(io_offset),
        .flash_offset(flash_offset), .rdata(rdata), .rdata_valid(rdata_valid),
        .cfg_cycle(cfg_cycle), .default_map(default_map));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // generous cut-off of 2000 cycles: the whole run is well under a hundred cycles
    initial begin
        #(2000 * 40);
        errors++;
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        boot_flash_bank_select = 1'b0;
        boot_bank_jumper = 1'b0;
        map_load = 1'b0;
        repeat (5) @(negedge core_clk);
        chk("reset map", 32'(1), 32'(default_map));
        rstn = 1'b1;
        $display("test reset ended");
        foreach (rows[i]) begin
            u_m.req(rows[i].a, 1'b0, 32'h0000_0000, 1'b0);
            chk("route", 32'(rows[i].e), 32'(hit));
        end
        $display("test map table ended");
        boot_flash_bank_select = 1'b1;
        u_m.req(32'hFFF0_0100, 1'b0, 32'h0000_0000, 1'b0);
        chk("bank b", 32'(6'h02), 32'(hit));
        boot_flash_bank_select = 1'b0;
        boot_bank_jumper = 1'b1;
        u_m.req(32'hFFFF_FFFC, 1'b0, 32'h0000_0000, 1'b0);
        chk("jumper bank", 32'(6'h02), 32'(hit));
        boot_bank_jumper = 1'b0;
        u_m.req(32'hFFFA_BCDE, 1'b0, 32'h0000_0000, 1'b0);
        chk("bank a", 32'(6'h04), 32'(hit));
        chk("flash offset", 32'h000A_BCDE, 32'(flash_offset));
        $display("test boot window ended");
        // write then read back to back, both config registers
        u_m.req(32'h8000_0CF8, 1'b1, 32'h1234_5678, 1'b1);
        u_m.req(32'h8000_0CF8, 1'b0, 32'h0000_0000, 1'b0);
        chk("cfg address", 32'h1234_5678, rdata);
        chk("cfg cycle", 32'(1), 32'(cfg_cycle & rdata_valid));
        u_m.req(32'h8000_0CFC, 1'b1, 32'hCAFE_F00D, 1'b1);
        u_m.req(32'h8000_0CFC, 1'b0, 32'h0000_0000, 1'b0);
        chk("cfg data", 32'hCAFE_F00D, rdata);
        u_m.req(32'h8000_0CF4, 1'b0, 32'h0000_0000, 1'b0);
        chk("near miss", 32'(0), 32'(cfg_cycle | rdata_valid));
        chk("io offset", 32'h0000_0CF4, 32'(io_offset));
        $display("test config ended");
        map_load = 1'b1;
        @(negedge core_clk);
        map_load = 1'b0;
        chk("map left", 32'(0), 32'(default_map));
        u_m.req(32'hFEF8_0000, 1'b0, 32'h0000_0000, 1'b0);
        chk("refused", 32'(0), 32'(hit));
        // second reset must bring the default map and a cleared data register back
        rstn = 1'b0;
        @(negedge core_clk);
        rstn = 1'b1;
        chk("map again", 32'(1), 32'(default_map));
        u_m.req(32'h8000_0CFC, 1'b0, 32'h0000_0000, 1'b0);
        chk("cfg cleared", 32'h0000_0000, rdata);
        $display("test map load and reset ended");
        wrap_up();
    end
endmodule : tb
